// *** src/sfcr_pkg.sv ***
// package: opcodes, status layout, phase counts and timing of the flash front end
package sfcr_pkg;
  // ------------------------------------------------------------------
  // command opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  // ------------------------------------------------------------------
  // status register layout
  // ------------------------------------------------------------------
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned WEL_BIT = 1;
  localparam int unsigned LOCK_BIT = 7;
  localparam logic [7:0] NV_MASK = 8'hBC;   // lock, top/bottom, protect range
  localparam logic [7:0] NV_RESET = 8'h00;  // factory state of the writable bits
  // ------------------------------------------------------------------
  // frame phase lengths, counted in link clock rising edges
  // ------------------------------------------------------------------
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
  localparam logic [4:0] ADDR_LAST_DUAL = 5'h0B;
  localparam logic [4:0] MODE_LAST = 5'h03;
  localparam logic [4:0] DUMMY_LAST = 5'h07;
  localparam logic [4:0] WSR_BITS = 5'h08;
  localparam logic [4:0] CNT_SAT = 5'h1F;
  localparam logic [1:0] CONT_KEEP = 2'h2;
  localparam logic [15:0] CONT_EXIT = 16'hFFFF;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;
  // ------------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WSR_TIME_US = 10000;
  // ------------------------------------------------------------------
  // frame states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_STAT, ST_WSR, ST_IGNORE
  } sfcr_state_type;
endpackage

// *** src/sfcr_top.sv ***
// serial flash command front end: frame decoder, status register and read data path
// ------------------------------------------------------------------
// Overview of operation
// - opcode 06h sets the write enable latch
// - writes refused while the latch is zero
// - opcode 04h clears the write enable latch
// - latch clears at reset and write completion
// - 05h shifts status out MSB first, falling edges
// - status read accepted even while busy
// - status byte repeats until chip select rises
// - 01h plus one byte, needs latch set
// - status write touches bits 7,5,4,3,2 only
// - status write discarded unless exactly eight bits
// - self-timed write cycle, then clear busy, latch
// - lock bit plus low protect pin blocks writes
// - 03h plus 24-bit address, data MSB first
// - address increments per byte until frame ends
// - read while busy is ignored
// - 0Bh adds eight ignored dummy clocks
// - 3Bh outputs two bits per clock
// - BBh takes address and mode bits dual
// - mode select 10 skips next opcode
// - other mode select returns to opcode decoding
// - low mode nibble ignored; host tristates lines
// - even bits on low line, odd high
// - sixteen ones leave continuous read mode
// - while busy only status read is honoured
// ------------------------------------------------------------------
`timescale 1ns/1ps

// ------------------------------------------------------------------
// read data buffer between array and output shifter
// ------------------------------------------------------------------
module sfcr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];  // word storage, no reset needed
  logic [PW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [PW:0] level, next_level;
  logic room, next_room;  // registered so ready comes from a flop
  logic avail, next_avail;
  logic push, pull;

  // pointer and level update; flush wins over both sides
  always_comb begin
    push = in_valid_i & room;
    pull = out_ready_i & avail;
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pull ? rptr + 1'b1 : rptr;
    next_level = level + (PW+1)'(push) - (PW+1)'(pull);
    if (flush_i) begin
      next_wptr = '0;
      next_rptr = '0;
      next_level = '0;
    end
    next_room = next_level != (PW+1)'(DEPTH);
    next_avail = next_level != '0;
  end

  // state registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
      level <= '0;
      room <= 1'b1;
      avail <= 1'b0;
    end else if (ce_i) begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      level <= next_level;
      room <= next_room;
      avail <= next_avail;
    end
  end

  // storage write
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push && !flush_i) begin
      store[wptr] <= in_data_i;
    end
  end

  assign in_ready_o = room;
  assign out_valid_o = avail;
  assign out_data_o = store[rptr];
endmodule

// ------------------------------------------------------------------
// top: frame decoder behind the serial pins
// ------------------------------------------------------------------
module sfcr_top #(
  parameter int unsigned WSR_CYCLES = sfcr_pkg::WSR_TIME_US * 1000 / sfcr_pkg::CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // serial pins
  input wire logic spi_cs_n_i,
  input wire logic spi_clk_i,
  input wire logic write_protect_n_i,
  input wire logic dual_line_low_i,
  output logic dual_line_low_o,
  output logic dual_line_low_oe_o,
  input wire logic dual_line_high_i,
  output logic dual_line_high_o,
  output logic dual_line_high_oe_o,
  // program/erase engine
  input wire logic engine_busy_i,
  input wire logic engine_done_i,
  // array read port
  output logic mem_rd_o,
  output logic [sfcr_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [sfcr_pkg::FIFO_WIDTH-1:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  output logic mem_ready_o
);
  import sfcr_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // shift one or two line bits into the capture register
  function automatic logic [23:0] shift_in(logic [23:0] v, logic dual, logic hi, logic lo);
    shift_in = dual ? {v[21:0], hi, lo} : {v[22:0], lo};
  endfunction

  // live status byte
  function automatic logic [7:0] status_of(logic [7:0] nvb, logic latch, logic busy);
    status_of = nvb & NV_MASK;
    status_of[WEL_BIT] = latch;
    status_of[BUSY_BIT] = busy;
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers: {wp, high, low, clk, cs}
  // ------------------------------------------------------------------
  logic [4:0] sync1, sync2, next_sync1, next_sync2;
  logic sck_d, next_sck_d;  // edge finder reads stage two only

  // next values of the sampling chain
  always_comb begin
    next_sync1 = {write_protect_n_i, dual_line_high_i, dual_line_low_i, spi_clk_i, spi_cs_n_i};
    next_sync2 = sync1;
    next_sck_d = sync2[1];
  end

  // sampling chain registers; link clock resets to its idle low level
  // so that no false edge is seen right after reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 5'h1D;
      sync2 <= 5'h1D;
      sck_d <= 1'b0;
    end else if (ce_i) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sck_d <= next_sck_d;
    end
  end

  logic cs_hi, rise, fall, d0, d1, wp_n;
  assign cs_hi = sync2[0];
  assign rise = sync2[1] & ~sck_d;  // data lines share the clock's latency
  assign fall = ~sync2[1] & sck_d;
  assign d0 = sync2[2];
  assign d1 = sync2[3];
  assign wp_n = sync2[4];

  // ------------------------------------------------------------------
  // frame state
  // ------------------------------------------------------------------
  sfcr_state_type st, next_st;
  logic [4:0] cnt, next_cnt;  // rising edges in the current phase
  logic [23:0] sh, next_sh;  // opcode, address and data capture
  logic [5:0] mb, next_mb;  // mode bits collected so far
  logic dual_in, next_dual_in, dual_out, next_dual_out;
  logic dummy, next_dummy;
  logic cont, next_cont;  // continuous read armed
  logic cont_frame, next_cont_frame;  // this frame started without opcode
  logic write_enable_latch, next_wel;
  logic [7:0] nv, next_nv;  // writable status bits
  logic wbusy, next_wbusy;
  logic [31:0] wtimer, next_wtimer;
  logic [7:0] wdata, next_wdata;
  logic [7:0] tx, next_tx;  // output shifter
  logic [2:0] txcnt, next_txcnt;
  logic out_hi, next_out_hi, out_lo, next_out_lo;
  logic oe_hi, next_oe_hi, oe_lo, next_oe_lo;
  logic fetch_on, next_fetch_on;
  logic [23:0] addr, next_addr;
  logic mem_rd, next_mem_rd;
  logic [23:0] mem_addr, next_mem_addr;
  logic pend, next_pend;  // one array read in flight

  logic busy_any, pop, flush, f_room, f_valid;
  logic [7:0] f_data, op, byte_v;
  logic [23:0] sh_in;
  logic [7:0] mb_in;

  assign busy_any = wbusy | engine_busy_i;
  assign sh_in = shift_in(sh, dual_in & (st == ST_ADDR), d1, d0);
  assign op = sh_in[7:0];
  assign mb_in = {mb, d1, d0};

  // next values for the frame decoder and status register
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_mb = mb;
    next_dual_in = dual_in;
    next_dual_out = dual_out;
    next_dummy = dummy;
    next_cont = cont;
    next_cont_frame = cont_frame;
    next_wel = write_enable_latch;
    next_nv = nv;
    next_wbusy = wbusy;
    next_wtimer = wtimer;
    next_wdata = wdata;
    next_tx = tx;
    next_txcnt = txcnt;
    next_out_hi = out_hi;
    next_out_lo = out_lo;
    next_oe_hi = oe_hi;
    next_oe_lo = oe_lo;
    next_fetch_on = fetch_on;
    next_addr = addr;
    next_mem_rd = 1'b0;
    next_mem_addr = mem_addr;
    next_pend = pend;
    pop = 1'b0;
    flush = 1'b0;
    byte_v = UNDERRUN_BYTE;
    // self-timed status write; only the writable bits land
    if (wbusy) begin
      if (wtimer == 32'(WSR_CYCLES - 1)) begin
        next_wbusy = 1'b0;
        next_nv = wdata & NV_MASK;
        next_wel = 1'b0;
      end else begin
        next_wtimer = wtimer + 32'h1;
      end
    end
    // program or erase finished behind us
    if (engine_done_i) begin
      next_wel = 1'b0;
    end
    // prefetch one byte at a time while the buffer has room
    if (fetch_on && !pend && f_room) begin
      next_mem_rd = 1'b1;
      next_mem_addr = addr;
      next_addr = addr + 24'h1;
      next_pend = 1'b1;
    end
    if (mem_rvalid_i && f_room) begin
      next_pend = 1'b0;
    end
    if (cs_hi) begin
      // frame end: a status write commits only on a whole byte
      if (st == ST_WSR && cnt == WSR_BITS) begin
        next_wbusy = 1'b1;
        next_wtimer = 32'h0;
        next_wdata = sh[7:0];
      end
      if (st != ST_IDLE) begin
        flush = 1'b1;
      end
      next_st = ST_IDLE;
      next_oe_hi = 1'b0;
      next_oe_lo = 1'b0;
      next_fetch_on = 1'b0;
      next_cont_frame = 1'b0;
    end else if (st == ST_IDLE) begin
      // frame start; armed continuous mode skips the opcode
      next_cnt = 5'h00;
      next_txcnt = 3'h0;
      next_st = ST_OPC;
      if (cont) begin
        next_st = busy_any ? ST_IGNORE : ST_ADDR;
        next_dual_in = 1'b1;
        next_dual_out = 1'b1;
        next_dummy = 1'b0;
        next_cont_frame = 1'b1;
      end
    end else if (rise) begin
      case (st)
        ST_OPC: begin
          next_sh = sh_in;
          next_cnt = cnt + 5'h01;
          if (cnt == OPC_LAST) begin
            next_cnt = 5'h00;
            next_st = ST_IGNORE;
            next_dual_in = 1'b0;
            next_dual_out = 1'b0;
            next_dummy = 1'b0;
            if (busy_any && op != OP_READ_STATUS) begin
              next_st = ST_IGNORE;
            end else begin
              case (op)
                OP_WRITE_ENABLE: next_wel = 1'b1;
                OP_WRITE_DISABLE: next_wel = 1'b0;
                OP_READ_STATUS: next_st = ST_STAT;
                OP_WRITE_STATUS: begin
                  // lock bit makes the protect pin count
                  if (write_enable_latch && !(nv[LOCK_BIT] && !wp_n)) begin
                    next_st = ST_WSR;
                  end
                end
                OP_READ: next_st = ST_ADDR;
                OP_FAST_READ: begin
                  next_st = ST_ADDR;
                  next_dummy = 1'b1;
                end
                OP_DUAL_OUT_READ: begin
                  next_st = ST_ADDR;
                  next_dummy = 1'b1;
                  next_dual_out = 1'b1;
                end
                OP_DUAL_IO_READ: begin
                  next_st = ST_ADDR;
                  next_dual_in = 1'b1;
                  next_dual_out = 1'b1;
                end
                default: next_st = ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          next_sh = sh_in;
          next_cnt = cnt + 5'h01;
          if (cont_frame && cnt == OPC_LAST && sh_in[15:0] == CONT_EXIT) begin
            next_cont = 1'b0;
            next_st = ST_IGNORE;
          end else if (cnt == (dual_in ? ADDR_LAST_DUAL : ADDR_LAST_SINGLE)) begin
            next_cnt = 5'h00;
            next_addr = sh_in;
            next_fetch_on = 1'b1;  // fetch overlaps mode and dummy clocks
            next_st = dual_in ? ST_MODE : (dummy ? ST_DUMMY : ST_DATA);
          end
        end
        ST_MODE: begin
          next_mb = mb_in[5:0];
          next_cnt = cnt + 5'h01;
          if (cnt == MODE_LAST) begin
            // only bits 5:4 matter; the low nibble is ignored
            next_cont = mb_in[5:4] == CONT_KEEP;
            next_st = ST_DATA;
          end
        end
        ST_DUMMY: begin
          next_cnt = cnt + 5'h01;  // line values ignored
          if (cnt == DUMMY_LAST) begin
            next_st = ST_DATA;
          end
        end
        ST_WSR: begin
          next_sh = sh_in;
          if (cnt != CNT_SAT) begin
            next_cnt = cnt + 5'h01;
          end
        end
        default: next_st = st;
      endcase
    end else if (fall) begin
      case (st)
        ST_STAT: begin
          // status reloads live at each byte boundary
          next_oe_hi = 1'b1;
          if (txcnt == 3'h0) begin
            byte_v = status_of(nv, write_enable_latch, busy_any);
            next_out_hi = byte_v[7];
            next_tx = {byte_v[6:0], 1'b0};
            next_txcnt = 3'h7;
          end else begin
            next_out_hi = tx[7];
            next_tx = {tx[6:0], 1'b0};
            next_txcnt = txcnt - 3'h1;
          end
        end
        ST_DATA: begin
          // an empty buffer sends ones; the array must keep up
          next_oe_hi = 1'b1;
          next_oe_lo = dual_out;
          if (txcnt == 3'h0) begin
            pop = f_valid;
            if (f_valid) begin
              byte_v = f_data;
            end
            next_out_hi = byte_v[7];
            next_out_lo = byte_v[6];
            next_tx = dual_out ? {byte_v[5:0], 2'h0} : {byte_v[6:0], 1'b0};
            next_txcnt = dual_out ? 3'h3 : 3'h7;
          end else begin
            next_out_hi = tx[7];
            next_out_lo = tx[6];
            next_tx = dual_out ? {tx[5:0], 2'h0} : {tx[6:0], 1'b0};
            next_txcnt = txcnt - 3'h1;
          end
        end
        default: next_st = st;
      endcase
    end
  end

  // frame and status registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      cnt <= 5'h00;
      sh <= 24'h000000;
      mb <= 6'h00;
      dual_in <= 1'b0;
      dual_out <= 1'b0;
      dummy <= 1'b0;
      cont <= 1'b0;
      cont_frame <= 1'b0;
      write_enable_latch <= 1'b0;
      nv <= NV_RESET;
      wbusy <= 1'b0;
      wtimer <= 32'h0;
      wdata <= 8'h00;
      tx <= 8'h00;
      txcnt <= 3'h0;
      out_hi <= 1'b0;
      out_lo <= 1'b0;
      oe_hi <= 1'b0;
      oe_lo <= 1'b0;
      fetch_on <= 1'b0;
      addr <= 24'h000000;
      mem_rd <= 1'b0;
      mem_addr <= 24'h000000;
      pend <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      mb <= next_mb;
      dual_in <= next_dual_in;
      dual_out <= next_dual_out;
      dummy <= next_dummy;
      cont <= next_cont;
      cont_frame <= next_cont_frame;
      write_enable_latch <= next_wel;
      nv <= next_nv;
      wbusy <= next_wbusy;
      wtimer <= next_wtimer;
      wdata <= next_wdata;
      tx <= next_tx;
      txcnt <= next_txcnt;
      out_hi <= next_out_hi;
      out_lo <= next_out_lo;
      oe_hi <= next_oe_hi;
      oe_lo <= next_oe_lo;
      fetch_on <= next_fetch_on;
      addr <= next_addr;
      mem_rd <= next_mem_rd;
      mem_addr <= next_mem_addr;
      pend <= next_pend;
    end
  end

  // ------------------------------------------------------------------
  // read buffer; late answers after a frame are taken and dropped
  // ------------------------------------------------------------------
  sfcr_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) sfcr_fifo_i (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .flush_i(flush),
    .in_valid_i(mem_rvalid_i & fetch_on),
    .in_data_i(mem_rdata_i),
    .in_ready_o(f_room),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(pop)
  );

  assign dual_line_high_o = out_hi;
  assign dual_line_high_oe_o = oe_hi;
  assign dual_line_low_o = out_lo;
  assign dual_line_low_oe_o = oe_lo;
  assign mem_rd_o = mem_rd;
  assign mem_addr_o = mem_addr;
  assign mem_ready_o = f_room;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_decode;
    ce_i && !cs_hi && rise && st == ST_OPC && cnt == OPC_LAST;
  endsequence
  sequence s_pop_dual;
    ce_i && pop && dual_out;
  endsequence

  a_wren_sets: assert property (s_decode ##0 (op == OP_WRITE_ENABLE && !busy_any && !engine_done_i) |=> write_enable_latch)
    else $error("write enable did not set latch");
  a_wrdi_clears: assert property (s_decode ##0 (op == OP_WRITE_DISABLE && !busy_any) |=> !write_enable_latch)
    else $error("write disable did not clear latch");
  a_wsr_refused: assert property (s_decode ##0 (op == OP_WRITE_STATUS && !write_enable_latch) |=> st == ST_IGNORE)
    else $error("status write taken without latch");
  a_wsr_locked: assert property (s_decode ##0 (op == OP_WRITE_STATUS && nv[LOCK_BIT] && !wp_n) |=> st != ST_WSR)
    else $error("locked status write taken");
  a_busy_ignore: assert property (s_decode ##0 (busy_any && op != OP_READ_STATUS) |=> st == ST_IGNORE)
    else $error("command honoured while busy");
  a_wsr_finish: assert property (ce_i && wbusy && wtimer == 32'(WSR_CYCLES - 1)
    |=> !wbusy && !write_enable_latch && nv == ($past(wdata) & NV_MASK))
    else $error("status write cycle end wrong");
  a_frame_end: assert property (ce_i && cs_hi && st != ST_IDLE |=> st == ST_IDLE && !oe_hi && !oe_lo)
    else $error("frame did not end on chip select");
  a_mode_keep: assert property (ce_i && !cs_hi && rise && st == ST_MODE && cnt == MODE_LAST
    |=> cont == ($past(mb_in[5:4]) == CONT_KEEP))
    else $error("continuous mode not taken from mode bits");
  a_dual_lanes: assert property (s_pop_dual |=> out_hi == $past(f_data[7]) && out_lo == $past(f_data[6]))
    else $error("dual lanes carry wrong bits");
endmodule

// *** test/sfcr_host.sv ***
// host model: chip select, link clock and both lanes of the serial bus
`timescale 1ns/1ps
module sfcr_host (
  // clock
  input wire logic clk_sys_i,
  // serial pins
  output logic spi_cs_n_o,
  output logic spi_clk_o,
  output logic lo_o,
  output logic hi_o,
  input wire logic lo_i,
  input wire logic hi_i
);
  initial begin
    spi_cs_n_o = 1'b1;
    spi_clk_o = 1'b0;
    lo_o = 1'b0;
    hi_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // one frame: n link clocks of 64 ns, lanes driven for the first nd, msb first
  task automatic frame(input int n, nd, input logic [63:0] li, hi, output logic [63:0] lq, hq);
    spi_cs_n_o <= 1'b0;
    wt(4);
    for (int i = 0; i < n; i++) begin
      spi_clk_o <= 1'b0;
      if (i < nd) begin
        lo_o <= li[n-1-i];
        hi_o <= hi[n-1-i];
      end else begin // released lanes drift off the last value
        lo_o <= ~lo_o;
        hi_o <= ~hi_o;
      end
      wt(4);
      spi_clk_o <= 1'b1;
      wt(4);
      lq[n-1-i] = lo_i;
      hq[n-1-i] = hi_i;
    end
    wt(4);
    spi_clk_o <= 1'b0;
    spi_cs_n_o <= 1'b1; // the caller picks n, so a write can end mid-byte
    wt(8);
  endtask
endmodule

// *** test/sfcr_top_bench.sv ***
// bench: host frames against the flash front end with a small array model
`timescale 1ns/1ps
module sfcr_top_bench;
  import sfcr_pkg::*;
  localparam int unsigned WSR_N = 800; // short write so busy can still be polled
  localparam logic [23:0] AD = 24'h000012;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, wp_n = 1'b1, done_e = 1'b0, mem_rv = 1'b0, eb = 1'b0;
  logic [7:0] mem_dat = 8'h00, s;
  logic cs_n, sclk, h_lo, h_hi, d_lo, d_lo_oe, d_hi, d_hi_oe, mem_rd, mem_rdy;
  logic [23:0] mem_adr;
  logic [63:0] ql, qh;
  int n_fail = 0, n_checks = 0, n_rd = 0, k;
  // lane level: device when enabled, otherwise host
  wire p_lo = d_lo_oe ? d_lo : h_lo;
  wire p_hi = d_hi_oe ? d_hi : h_hi;
  // table rows: opcode sent, status expected after it
  logic [7:0] r_op [5] = '{OP_WRITE_ENABLE, 8'h77, OP_WRITE_DISABLE, 8'h00, OP_WRITE_ENABLE};
  logic [7:0] r_st [5] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h02};
  always #4 clk_sys_i = ~clk_sys_i;
  // array model: byte is address xor 3Ch, one cycle after the request
  always @(posedge clk_sys_i) begin
    mem_rv <= mem_rd;
    mem_dat <= mem_adr[7:0] ^ 8'h3C;
    if (mem_rd === 1'b1) n_rd++;
  end
  sfcr_top #(.WSR_CYCLES(WSR_N)) sfcr_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
    .spi_cs_n_i(cs_n), .spi_clk_i(sclk), .write_protect_n_i(wp_n), .dual_line_low_i(p_lo),
    .dual_line_low_o(d_lo), .dual_line_low_oe_o(d_lo_oe), .dual_line_high_i(p_hi), .dual_line_high_o(d_hi),
    .dual_line_high_oe_o(d_hi_oe), .engine_busy_i(eb), .engine_done_i(done_e), .mem_rd_o(mem_rd),
    .mem_addr_o(mem_adr), .mem_rdata_i(mem_dat), .mem_rvalid_i(mem_rv), .mem_ready_o(mem_rdy));
  sfcr_host sfcr_host_i (.clk_sys_i(clk_sys_i), .spi_cs_n_o(cs_n), .spi_clk_o(sclk), .lo_o(h_lo),
    .hi_o(h_hi), .lo_i(p_lo), .hi_i(p_hi));
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fr(input int n, nd, input logic [63:0] li, hi);
    sfcr_host_i.frame(n, nd, li, hi, ql, qh);
  endtask
  task automatic cmd(input logic [7:0] op);
    fr(8, 8, {56'h0, op}, 64'h0);
  endtask
  task automatic st();
    fr(16, 8, {48'h0, OP_READ_STATUS, 8'h00}, 64'h0);
    s = qh[7:0];
  endtask
  // one lane of a 32-bit value sent two bits per clock
  function automatic logic [15:0] dsp(input logic [31:0] v, input int odd);
    for (int i = 0; i < 16; i++) dsp[i] = v[2*i+odd];
  endfunction
  function automatic logic [7:0] ilv(input logic [3:0] h, l);
    ilv = {h[3], l[3], h[2], l[2], h[1], l[1], h[0], l[0]};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog: the run needs about 10800 clocks
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    for (k = 0; k < 5; k++) begin
      cmd(r_op[k]);
      st();
      chk("status", r_st[k], s);
    end
    done_e <= 1'b1;
    @(posedge clk_sys_i);
    done_e <= 1'b0;
    st();
    chk("status", 8'h00, s);
    eb <= 1'b1;
    cmd(OP_WRITE_ENABLE);
    st();
    chk("status", 8'h01, s);
    eb <= 1'b0;
    fr(16, 16, {48'h0, OP_WRITE_STATUS, 8'hFF}, 64'h0);
    repeat (900) @(posedge clk_sys_i);
    st();
    chk("status", 8'h00, s);
    cmd(OP_WRITE_ENABLE);
    fr(15, 15, {49'h0, OP_WRITE_STATUS, 7'h7F}, 64'h0);
    repeat (900) @(posedge clk_sys_i);
    st();
    chk("status", 8'h02, s);
    $display("test latch done");
    fr(16, 16, {48'h0, OP_WRITE_STATUS, 8'hFF}, 64'h0);
    st();
    chk("status", 8'h03, s);
    k = n_rd;
    fr(40, 32, {24'h0, OP_READ, AD, 8'h00}, 64'h0);
    chk("reads", 8'(k), 8'(n_rd));
    repeat (900) @(posedge clk_sys_i);
    st();
    chk("status", 8'hBC, s);
    wp_n <= 1'b0;
    cmd(OP_WRITE_ENABLE);
    fr(16, 16, {48'h0, OP_WRITE_STATUS, 8'h00}, 64'h0);
    repeat (900) @(posedge clk_sys_i);
    st();
    chk("status", 8'hBE, s);
    wp_n <= 1'b1;
    fr(16, 16, {48'h0, OP_WRITE_STATUS, 8'h00}, 64'h0);
    repeat (900) @(posedge clk_sys_i);
    st();
    chk("status", 8'h00, s);
    $display("test status write done");
    fr(48, 32, {16'h0, OP_READ, AD, 16'h0}, 64'h0);
    chk("read0", 8'h2E, qh[15:8]);
    chk("read1", 8'h2F, qh[7:0]);
    fr(48, 40, {16'h0, OP_FAST_READ, AD, 16'h0}, 64'h0);
    chk("fast", 8'h2E, qh[7:0]);
    fr(44, 40, {20'h0, OP_DUAL_OUT_READ, AD, 12'h0}, 64'h0);
    chk("dual", 8'h2E, ilv(qh[3:0], ql[3:0]));
    fr(28, 24, {36'h0, OP_DUAL_IO_READ, dsp({AD, 8'h20}, 0), 4'h0}, {44'h0, dsp({AD, 8'h20}, 1), 4'h0});
    chk("dualio", 8'h2E, ilv(qh[3:0], ql[3:0]));
    fr(20, 16, {44'h0, dsp({AD + 24'h1, 8'h0F}, 0), 4'h0}, {44'h0, dsp({AD + 24'h1, 8'h0F}, 1), 4'h0});
    chk("cont", 8'h2F, ilv(qh[3:0], ql[3:0]));
    st();
    chk("status", 8'h00, s);
    fr(28, 24, {36'h0, OP_DUAL_IO_READ, dsp({AD, 8'h20}, 0), 4'h0}, {44'h0, dsp({AD, 8'h20}, 1), 4'h0});
    fr(8, 8, 64'hFF, 64'hFF);
    st();
    chk("status", 8'h00, s);
    $display("test reads done");
    cmd(OP_WRITE_ENABLE);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    st();
    chk("status", 8'h00, s);
    chk("ready", 8'h01, {7'h0, mem_rdy});
    cmd(OP_WRITE_ENABLE);
    fr(24, 8, {40'h0, OP_READ_STATUS, 16'h0}, 64'h0);
    chk("status0", 8'h02, qh[15:8]);
    chk("status1", 8'h02, qh[7:0]);
    chk("oe", 8'h00, {6'h0, d_hi_oe, d_lo_oe});
    $display("test reset done");
    test_done();
  end
endmodule
